/* verilog/gate_timer_pkg.sv */
package gate_timer_pkg;

    // =====================================================================
    // register indices on the plain register port
    // =====================================================================
    localparam logic [2:0] ADDR_TIMER_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNT_LOW     = 3'h1;
    localparam logic [2:0] ADDR_COUNT_HIGH    = 3'h2;
    localparam logic [2:0] ADDR_CMP_LINK      = 3'h3;
    localparam logic [2:0] ADDR_FLAGS         = 3'h4;
    localparam logic [2:0] ADDR_IRQ_ENABLES   = 3'h5;

    // =====================================================================
    // timer_control fields
    // =====================================================================
    localparam int BIT_GATE_POLARITY  = 7;
    localparam int BIT_GATE_ENABLE    = 6;
    localparam int BIT_PRESCALE_HI    = 5;
    localparam int BIT_PRESCALE_LO    = 4;
    localparam int BIT_LP_OSC_ENABLE  = 3;
    localparam int BIT_NO_SYNC        = 2;
    localparam int BIT_SOURCE_SELECT  = 1;
    localparam int BIT_COUNTER_ON     = 0;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;

    // comparator_two_timer_link fields
    localparam int BIT_GATE_SOURCE_SELECT = 1;
    localparam int BIT_CMP_SYNC_ENABLE    = 0;
    localparam logic [1:0] CMP_LINK_RESET = 2'h2;

    // irq enable register fields
    localparam int BIT_OVF_IRQ_ENABLE    = 0;
    localparam int BIT_PERIPH_IRQ_ENABLE = 1;
    localparam int BIT_GLOBAL_IRQ_ENABLE = 2;

    localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [2:0]  PRE_ZERO   = 3'h0;

    // fixed interrupt service entry address
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

endpackage

/* verilog/sync2.sv */
`timescale 1ns/100ps
module sync2
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // level in and synchronised level out
    input  wire logic din,
    output logic      dout
);
    logic [1:0] stage_q;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            stage_q <= 2'h0;
        else
            stage_q <= {stage_q[0], din};
    end

    assign dout = stage_q[1];
endmodule

/* verilog/gate_timer.sv */
// Behaviour
// R1 - reads of count bytes always stable
// R2 - software stops counter before writing bytes
// R3 - gated counter increments only while gate active
// R4 - gate enable ignored when off, else gates
// R5 - polarity bit chooses high or low gate
// R6 - wrap FFFFh to 0000h sets overflow flag
// R7 - interrupt needs four enable bits set
// R8 - overflow flag held until software clears
// R9 - software clears count and flag first
// R10 - sleep counting and wake only async external
// R11 - wake resumes, vectors when global enabled
// R12 - count drives capture copy and compare match
// R13 - special event clears count, no flag
// R14 - software write beats special event clear
// R15 - software uses sync mode with trigger
// R16 - comparator output optionally synced to increment
// R17 - falling edge needed before first rising edge
// R18 - prescale 1:1, 1:2, 1:4, 1:8
// R19 - low-power oscillator only in internal-osc mode
// R20 - no-sync bit only with external source
// R21 - source bit picks pin or Fosc/4
// R22 - counter-on bit; control resets zero
// R23 - count write clears prescale counter
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module gate_timer
    import gate_timer_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // external pins and sources
    input  wire logic        count_input_pin,
    input  wire logic        low_power_osc,
    input  wire logic        gate_pin,
    input  wire logic        comparator_two_output,
    // system state
    input  wire logic        internal_osc_no_clkout,
    input  wire logic        sleep_mode,
    // capture/compare unit
    input  wire logic        capture_event,
    input  wire logic        special_event,
    input  wire logic [15:0] compare_value,
    // outputs to the core
    output logic [15:0]      capture_value,
    output logic             compare_match,
    output logic             overflow_flag,
    output logic             irq_request,
    output logic             wake_request,
    output logic [15:0]      irq_vector
);
    // =====================================================================
    // synchronisers for the four external pin and source inputs
    // =====================================================================
    logic pin_s, lp_s, gate_s, cmp_s;

    sync2 u_sync_pin  (.ref_clk(ref_clk), .srst(srst), .din(count_input_pin), .dout(pin_s));
    sync2 u_sync_lp   (.ref_clk(ref_clk), .srst(srst), .din(low_power_osc),   .dout(lp_s));
    sync2 u_sync_gate (.ref_clk(ref_clk), .srst(srst), .din(gate_pin),        .dout(gate_s));
    sync2 u_sync_cmp  (.ref_clk(ref_clk), .srst(srst), .din(comparator_two_output),
                       .dout(cmp_s));

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic [7:0]  control;
        logic [1:0]  cmp_link;
        logic [2:0]  irq_en;
        logic [15:0] count;
        logic [2:0]  pre;
        logic        ext_prev;
        logic        armed;
        logic        cmp_held;
        logic        flag;
        logic        prev_on;
        logic [15:0] capture;
        logic        match;
        logic [7:0]  rdata;
    } state_t;

    state_t state_q, state_d;

    logic       counter_on, gate_enable, gate_polarity, no_sync, ext_src, lp_en;
    logic [1:0] prescale_select;
    logic       ext_level, ext_rise, ext_fall, tick, gate_src, gate_ok, pre_out;
    logic       count_write, wrap;
    logic [2:0] pre_mask;

    always_comb
    begin
        counter_on      = state_q.control[BIT_COUNTER_ON];                   // see R22
        gate_enable     = state_q.control[BIT_GATE_ENABLE];
        gate_polarity   = state_q.control[BIT_GATE_POLARITY];
        prescale_select = state_q.control[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
        ext_src         = state_q.control[BIT_SOURCE_SELECT];
        no_sync         = state_q.control[BIT_NO_SYNC] & ext_src;            // see R20
        lp_en           = state_q.control[BIT_LP_OSC_ENABLE] & internal_osc_no_clkout; // see R19

        // external clock level: pin or low-power oscillator
        ext_level = lp_en ? lp_s : pin_s;
        ext_rise  = ext_level & ~state_q.ext_prev;
        ext_fall  = ~ext_level & state_q.ext_prev;

        // count clock: rising external edge or every cycle as Fosc/4
        tick = ext_src ? (ext_rise & state_q.armed) : 1'b1;                 // see R21, R17

        // comparator may be held at increment edges
        gate_src = state_q.cmp_link[BIT_GATE_SOURCE_SELECT]
                 ? (state_q.cmp_link[BIT_CMP_SYNC_ENABLE] ? state_q.cmp_held : cmp_s)  // see R16
                 : gate_s;                                                   // see R3
        gate_ok  = ~gate_enable | (gate_src == gate_polarity);              // see R4, R5

        // sleep stops all but async external counting
        pre_mask = (prescale_select == 2'h0) ? 3'h0 :
                   (prescale_select == 2'h1) ? 3'h1 :
                   (prescale_select == 2'h2) ? 3'h3 : 3'h7;                 // see R18
        pre_out  = ((state_q.pre & pre_mask) == pre_mask);

        count_write = reg_wr & ((reg_addr == ADDR_COUNT_LOW) | (reg_addr == ADDR_COUNT_HIGH));

        state_d       = state_q;
        state_d.match = 1'b0;
        wrap          = 1'b0;
        state_d.prev_on  = counter_on;
        state_d.ext_prev = ext_level;

        // falling edge rearms after enable or write
        if (ext_fall)
            state_d.armed = 1'b1;                                            // see R17
        if (count_write || (counter_on && !state_q.prev_on) || !counter_on)
            state_d.armed = ext_fall;

        if (tick)
            state_d.cmp_held = cmp_s;

        if (counter_on && gate_ok && tick && !(sleep_mode && !(no_sync && ext_src)))  // see R10
        begin
            if (pre_out)
            begin
                state_d.pre   = PRE_ZERO;
                state_d.count = state_q.count + 16'h0001;                   // see R6
                wrap          = (state_q.count == COUNT_MAX);
            end
            else
                state_d.pre = state_q.pre + 3'h1;
        end

        if (special_event && !no_sync)
            state_d.count = COUNT_ZERO;                                      // see R13

        if (wrap)
            state_d.flag = 1'b1;                                             // see R6

        if (reg_wr)
        begin
            if (reg_addr == ADDR_TIMER_CONTROL)
                state_d.control = reg_wdata;
            else if (reg_addr == ADDR_COUNT_LOW)
            begin
                state_d.count[7:0] = reg_wdata;                             // see R14
                state_d.pre        = PRE_ZERO;                              // see R23
            end
            else if (reg_addr == ADDR_COUNT_HIGH)
            begin
                state_d.count[15:8] = reg_wdata;                            // see R14
                state_d.pre         = PRE_ZERO;                             // see R23
            end
            else if (reg_addr == ADDR_CMP_LINK)
                state_d.cmp_link = reg_wdata[1:0];
            else if (reg_addr == ADDR_FLAGS)
                state_d.flag = wrap | reg_wdata[0];                         // see R8
            else if (reg_addr == ADDR_IRQ_ENABLES)
                state_d.irq_en = reg_wdata[2:0];
        end

        if (capture_event)
            state_d.capture = state_q.count;                                // see R12
        state_d.match = (compare_value == state_q.count);                  // see R12

        // reads come from synchronised count state only
        if (!reg_rd)
            state_d.rdata = 8'h00;
        else if (reg_addr == ADDR_TIMER_CONTROL)
            state_d.rdata = state_q.control;
        else if (reg_addr == ADDR_COUNT_LOW)
            state_d.rdata = state_q.count[7:0];                             // see R1
        else if (reg_addr == ADDR_COUNT_HIGH)
            state_d.rdata = state_q.count[15:8];                            // see R1
        else if (reg_addr == ADDR_CMP_LINK)
            state_d.rdata = {6'h00, state_q.cmp_link};
        else if (reg_addr == ADDR_FLAGS)
            state_d.rdata = {7'h00, state_q.flag};
        else if (reg_addr == ADDR_IRQ_ENABLES)
            state_d.rdata = {5'h00, state_q.irq_en};
        else
            state_d.rdata = 8'h00;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_q          <= '0;
            state_q.control  <= TIMER_CONTROL_RESET;                       // see R22
            state_q.cmp_link <= CMP_LINK_RESET;
        end
        else
            state_q <= state_d;
    end

    // =====================================================================
    // outputs
    // =====================================================================
    logic ovf_path;
    assign ovf_path      = state_q.flag & state_q.control[BIT_COUNTER_ON]
                         & state_q.irq_en[BIT_OVF_IRQ_ENABLE]
                         & state_q.irq_en[BIT_PERIPH_IRQ_ENABLE];
    assign reg_rdata     = state_q.rdata;
    assign capture_value = state_q.capture;
    assign compare_match = state_q.match;
    assign overflow_flag = state_q.flag;
    assign irq_request   = ovf_path & state_q.irq_en[BIT_GLOBAL_IRQ_ENABLE];   // see R7
    assign wake_request  = ovf_path & state_q.control[BIT_NO_SYNC]
                         & state_q.control[BIT_SOURCE_SELECT];                // see R10, R11
    assign irq_vector    = IRQ_VECTOR;                                       // see R11

    // =====================================================================
    // checks
    // =====================================================================
    AST_WRAP_FLAG: assert property (@(posedge ref_clk) disable iff (srst)   // see R6
        (wrap && !reg_wr) |=> overflow_flag && (state_q.count == COUNT_ZERO))
        else $error("wrap did not set flag or zero count");

    AST_FLAG_HOLD: assert property (@(posedge ref_clk) disable iff (srst)   // see R8
        (overflow_flag && !(reg_wr && reg_addr == ADDR_FLAGS)) |=> overflow_flag)
        else $error("overflow flag dropped without clear");

    AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (srst)    // see R7
        irq_request |-> overflow_flag && state_q.irq_en == 3'h7
                        && state_q.control[BIT_COUNTER_ON])
        else $error("interrupt without all enables");

    AST_OFF_HOLD: assert property (@(posedge ref_clk) disable iff (srst)    // see R22
        (!counter_on && !reg_wr && !special_event) |=> $stable(state_q.count))
        else $error("count moved while off");

    AST_GATE_HOLD: assert property (@(posedge ref_clk) disable iff (srst)   // see R3
        (counter_on && gate_enable && !gate_ok && !reg_wr && !special_event)
        |=> $stable(state_q.count))
        else $error("count moved with gate inactive");

    AST_WRITE_WINS: assert property (@(posedge ref_clk) disable iff (srst)  // see R14
        (reg_wr && reg_addr == ADDR_COUNT_LOW) |=> state_q.count[7:0] == $past(reg_wdata))
        else $error("count write lost");

    AST_SPECIAL_CLEAR: assert property (@(posedge ref_clk) disable iff (srst) // see R13
        (special_event && !no_sync && !reg_wr) |=> state_q.count == COUNT_ZERO)
        else $error("special event did not clear count");

    AST_PRE_CLEAR: assert property (@(posedge ref_clk) disable iff (srst)   // see R23
        (reg_wr && reg_addr == ADDR_COUNT_HIGH) |=> state_q.pre == PRE_ZERO)
        else $error("prescaler not cleared by count write");

    // =====================================================================
    // multi-step checks
    // =====================================================================
    // a wrap in async external mode with both enables raises wake
    sequence s_async_wrap;
        wrap && no_sync && !reg_wr
        && state_q.irq_en[BIT_OVF_IRQ_ENABLE]
        && state_q.irq_en[BIT_PERIPH_IRQ_ENABLE];
    endsequence

    sequence s_wake_raised;
        wake_request && overflow_flag;
    endsequence

    AST_WAKE_ON_WRAP: assert property (@(posedge ref_clk) disable iff (srst) // see R10
        s_async_wrap |=> s_wake_raised)
        else $error("async wrap did not raise wake");

    AST_SLEEP_HOLD: assert property (@(posedge ref_clk) disable iff (srst)  // see R10
        (sleep_mode && !no_sync && !reg_wr && !special_event) |=> $stable(state_q.count))
        else $error("count moved in sleep");

    // a rise with no falling edge seen since enable or write
    sequence s_unarmed_rise;
        counter_on && ext_src && ext_rise && !state_q.armed
        && !reg_wr && !special_event;
    endsequence

    AST_FIRST_EDGE: assert property (@(posedge ref_clk) disable iff (srst)  // see R17
        s_unarmed_rise |=> $stable(state_q.count))
        else $error("rise counted before a fall");

    AST_DISARM: assert property (@(posedge ref_clk) disable iff (srst)      // see R17
        (count_write && !ext_fall) |=> !state_q.armed)
        else $error("count write left edge armed");

    // gate pin open at 1:1 on the internal clock
    sequence s_pin_gate_open;
        counter_on && gate_enable && !ext_src && (pre_mask == PRE_ZERO)
        && !state_q.cmp_link[BIT_GATE_SOURCE_SELECT] && (gate_s == gate_polarity)
        && !sleep_mode && !reg_wr && !special_event;
    endsequence

    AST_PIN_GATE_COUNT: assert property (@(posedge ref_clk) disable iff (srst) // see R3, R5
        s_pin_gate_open |=> state_q.count == $past(state_q.count) + 16'h0001)
        else $error("open gate did not count");

    AST_SPECIAL_IGNORED: assert property (@(posedge ref_clk) disable iff (srst) // see R13
        (special_event && no_sync && !tick && !reg_wr) |=> $stable(state_q.count))
        else $error("special event cleared async count");

    AST_WRITE_HIGH: assert property (@(posedge ref_clk) disable iff (srst)  // see R14
        (reg_wr && reg_addr == ADDR_COUNT_HIGH) |=> state_q.count[15:8] == $past(reg_wdata))
        else $error("count high write lost");

    AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (srst)  // see R8
        (reg_wr && reg_addr == ADDR_FLAGS && !reg_wdata[0] && !wrap) |=> !overflow_flag)
        else $error("flag clear ignored");

    AST_READ_LOW: assert property (@(posedge ref_clk) disable iff (srst)    // see R1
        (reg_rd && reg_addr == ADDR_COUNT_LOW) |=> reg_rdata == $past(state_q.count[7:0]))
        else $error("count low read wrong");

    AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (srst)     // see R12
        capture_event |=> capture_value == $past(state_q.count))
        else $error("capture missed the count");

    AST_MATCH: assert property (@(posedge ref_clk) disable iff (srst)       // see R12
        (compare_value == state_q.count) |=> compare_match)
        else $error("compare match missing");

    AST_NO_MATCH: assert property (@(posedge ref_clk) disable iff (srst)    // see R12
        (compare_value != state_q.count) |=> !compare_match)
        else $error("false compare match");
endmodule

/* tb/ext_source.sv */
`timescale 1ns/100ps
module ext_source
(
    // pins toward the timer
    output logic count_input_pin,
    output logic low_power_osc,
    output logic gate_pin,
    output logic comparator_two_output
);
    // =====================================================
    // pin levels
    // =====================================================
    initial
    begin
        count_input_pin       = 1'b0;
        low_power_osc         = 1'b0;
        gate_pin              = 1'b0;
        comparator_two_output = 1'b0;
    end

    // count clock idles low between bursts
    task automatic pulses(input int n);
        repeat (n)
        begin
            #400 count_input_pin = 1'b1;
            #400 count_input_pin = 1'b0;
        end
    endtask

    // low-power oscillator idles low between bursts
    task automatic lp_pulses(input int n);
        repeat (n)
        begin
            #400 low_power_osc = 1'b1;
            #400 low_power_osc = 1'b0;
        end
    endtask

    // gate levels change as plain async levels
    task automatic set_gate(input logic g, input logic c);
        gate_pin              = g;
        comparator_two_output = c;
    endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench
    import gate_timer_pkg::*;
;
    logic        ref_clk, srst, reg_wr, reg_rd, sleep_mode, capture_event, special_event;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, a, b, h;
    logic [15:0] compare_value, capture_value, irq_vector;
    logic        cnt_pin, lp_osc, g_pin, c_out, osc_mode;
    logic        compare_match, overflow_flag, irq_request, wake_request;
    int          err_count, tests_run;
    // rows: link, control, gate pin/comparator, expected counts in 64 cycles
    localparam logic [1:0] LINK_T [11] = '{0, 0, 0, 0, 0, 0, 0, 2, 3, 0, 0};
    localparam logic [7:0] CTRL_T [11] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h41,
                                           8'hC1, 8'hC1, 8'hC1, 8'h40, 8'h05};
    localparam logic [1:0] GATE_T [11] = '{2, 2, 2, 2, 2, 0, 2, 0, 1, 0, 2};
    localparam logic [7:0] EXP_T  [11] = '{64, 32, 16, 8, 0, 64, 64, 0, 64, 0, 64};

    ext_source far_side (.count_input_pin(cnt_pin), .low_power_osc(lp_osc),
                         .gate_pin(g_pin), .comparator_two_output(c_out));

    gate_timer DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .count_input_pin(cnt_pin), .low_power_osc(lp_osc), .gate_pin(g_pin),
        .comparator_two_output(c_out), .internal_osc_no_clkout(osc_mode),
        .sleep_mode(sleep_mode), .capture_event(capture_event),
        .special_event(special_event), .compare_value(compare_value),
        .capture_value(capture_value), .compare_match(compare_match),
        .overflow_flag(overflow_flag), .irq_request(irq_request),
        .wake_request(wake_request), .irq_vector(irq_vector));

    // =====================================================
    // helpers
    // =====================================================
    always #50 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] ad, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // =====================================================
    // scenarios
    // =====================================================
    task automatic test_reset;
        rd(ADDR_TIMER_CONTROL, b);
        check({8'h00, b}, {8'h00, TIMER_CONTROL_RESET});
        rd(ADDR_CMP_LINK, b);
        check({14'h0, b[1:0]}, {14'h0, CMP_LINK_RESET});
        wr(3'h7, 8'hFF);
        rd(3'h7, b);
        check({8'h00, b}, 16'h0000);
        check(irq_vector, IRQ_VECTOR);
    endtask

    task automatic test_modes;
        for (int i = 0; i < 11; i++)
        begin
            wr(ADDR_CMP_LINK, {6'h00, LINK_T[i]});
            far_side.set_gate(GATE_T[i][1], GATE_T[i][0]);
            wr(ADDR_TIMER_CONTROL, CTRL_T[i]);
            repeat (4) @(posedge ref_clk);
            rd(ADDR_COUNT_LOW, a);
            repeat (62) @(posedge ref_clk);
            rd(ADDR_COUNT_LOW, b);
            check({8'h00, 8'(b - a)}, {8'h00, EXP_T[i]});
        end
        wr(ADDR_TIMER_CONTROL, 8'h00);
    endtask

    task automatic test_overflow;
        wr(ADDR_COUNT_HIGH, 8'hFF);
        wr(ADDR_COUNT_LOW, 8'hFE);
        wr(ADDR_IRQ_ENABLES, 8'h03);
        wr(ADDR_TIMER_CONTROL, 8'h01);
        for (int n = 0; n < 10 && overflow_flag !== 1'b1; n++) @(posedge ref_clk);
        @(negedge ref_clk);
        check(irq_request, 1'b0);
        rd(ADDR_FLAGS, b);
        check(b[0], 1'b1);
        wr(ADDR_IRQ_ENABLES, 8'h07);
        @(negedge ref_clk);
        check(irq_request, 1'b1);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        @(negedge ref_clk);
        check(irq_request, 1'b0);
        rd(ADDR_COUNT_HIGH, b);
        check({8'h00, b}, 16'h0000);
        repeat (20) @(negedge ref_clk);
        check(overflow_flag, 1'b1);
        wr(ADDR_FLAGS, 8'h00);
        @(negedge ref_clk);
        check(overflow_flag, 1'b0);
    endtask

    task automatic test_events;
        wr(ADDR_COUNT_HIGH, 8'h12);
        wr(ADDR_COUNT_LOW, 8'h34);
        wr(ADDR_TIMER_CONTROL, 8'h01);
        @(posedge ref_clk);
        special_event <= 1'b1;
        @(posedge ref_clk);
        special_event <= 1'b0;
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_COUNT_HIGH, b);
        check({8'h00, b}, 16'h0000);
        check(overflow_flag, 1'b0);
        @(posedge ref_clk);
        reg_addr      <= ADDR_COUNT_LOW;
        reg_wdata     <= 8'h5A;
        reg_wr        <= 1'b1;
        special_event <= 1'b1;
        @(posedge ref_clk);
        reg_wr        <= 1'b0;
        special_event <= 1'b0;
        rd(ADDR_COUNT_LOW, b);
        check({8'h00, b}, 16'h005A);
        rd(ADDR_COUNT_HIGH, h);
        @(posedge ref_clk);
        capture_event <= 1'b1;
        compare_value <= {h, 8'h5A};
        @(posedge ref_clk);
        capture_event <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check(capture_value, {h, 8'h5A});
        check(compare_match, 1'b1);
        @(posedge ref_clk);
        compare_value <= {h, 8'h5B};
        repeat (3) @(negedge ref_clk);
        check(compare_match, 1'b0);
    endtask

    task automatic test_external;
        wr(ADDR_COUNT_HIGH, 8'hFF);
        wr(ADDR_COUNT_LOW, 8'hFD);
        wr(ADDR_IRQ_ENABLES, 8'h03);
        sleep_mode <= 1'b1;
        wr(ADDR_TIMER_CONTROL, 8'h01);
        repeat (8) @(posedge ref_clk);
        rd(ADDR_COUNT_LOW, b);
        check({8'h00, b}, 16'h00FD);
        wr(ADDR_TIMER_CONTROL, 8'h07);
        special_event <= 1'b1;
        @(posedge ref_clk);
        special_event <= 1'b0;
        far_side.pulses(4);
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check(wake_request, 1'b1);
        check(irq_request, 1'b0);
        @(posedge ref_clk);
        sleep_mode <= 1'b0;
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_COUNT_LOW, b);
        check({8'h00, b}, 16'h0000);
    endtask

    task automatic test_lp;
        for (int m = 0; m < 2; m++)
        begin
            wr(ADDR_COUNT_LOW, 8'h00);
            osc_mode <= m[0];
            wr(ADDR_TIMER_CONTROL, 8'h0B);
            far_side.lp_pulses(5);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rd(ADDR_COUNT_LOW, b);
            check({8'h00, b}, m ? 16'h0004 : 16'h0000);
        end
    endtask

    // =====================================================
    // main sequence and watchdog
    // =====================================================
    initial
    begin
        ref_clk = 0; srst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        sleep_mode = 0; capture_event = 0; special_event = 0; compare_value = 0;
        err_count = 0; tests_run = 0; osc_mode = 0;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        test_reset;
        test_modes;
        test_overflow;
        test_events;
        test_external;
        test_lp;
        test_done;
    end

    initial
    begin
        #1_000_000;
        err_count++;
        test_done;
    end
endmodule
